//--- common/ext_bus_pkg.sv
// Summary of operation
// - compare register eight bits, upper bits zero
// - match sets flag, clears timer counter
// - enabled match raises refresh request
// - request stays pending until refresh done
// - match while pending keeps single request
// - keyed writes need upper half A55A
// - compare cleared only by power-on reset
// - wait counter counts up, stops at 7F
// - no external access while wait counting
// - keyed wait write reloads and restarts
// - wait counter bits above six read zero
// - big endian, offset zero is MSB
// - SDRAM only sixteen or thirty-two bits
// - muxed I/O area fixed thirty-two bits
// - wide access split, data reassembled
// - 32-bit port byte and word lanes
// - 32-bit longword drives all four strobes
// - 16-bit port lanes, longword two words
// - 8-bit port lane zero, ascending bytes
// - timer counter wraps 255 to zero
package ext_bus_pkg;
   localparam logic [3:0] OFF_CMP = 4'h0;
   localparam logic [3:0] OFF_WAIT = 4'h4;
   localparam logic [3:0] OFF_CTRL = 4'h8;
   localparam logic [3:0] OFF_TIMER = 4'hc;
   localparam logic [15:0] UNLOCK_KEY = 16'ha55a;
   localparam int KEY_LSB = 16;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [6:0] WAIT_RESET = 7'h00;
   localparam logic [6:0] WAIT_END = 7'h7f;
   localparam int CMP_W = 8;
   localparam int WAIT_W = 7;
   localparam int CTRL_EN = 0;
   localparam int CTRL_CMF = 1;
   localparam int CTRL_PEND = 2;
   localparam int CTRL_BUSY = 3;

   typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} size_t;
   typedef enum logic [1:0] {
      AREA_NORMAL = 2'b00, AREA_BSRAM = 2'b01, AREA_SDRAM = 2'b10, AREA_MPX = 2'b11
   } area_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_BEAT = 1'b1} xfer_state_t;

   typedef struct packed {
      logic [31:0] addr;
      size_t size;
      logic we;
      logic [31:0] wdata;
      area_t area;
      size_t port;
   } acc_req_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] dout;
      logic [3:0] strobe;
      logic [3:0] sdram_mask_n;
      logic we;
   } ext_bus_t;
endpackage

//--- verilog/ext_bus_refresh_wait_align.sv
`timescale 1ns/1ps
module ext_bus_refresh_wait_align
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_refresh_tick,
   input wire logic i_refresh_ack,
   output logic o_refresh_req,
   input wire logic i_acc_valid,
   input wire ext_bus_pkg::acc_req_t i_acc,
   output logic o_acc_ready,
   output logic o_rsp_valid,
   output logic [31:0] o_rsp_rdata,
   output logic o_ext_req,
   output ext_bus_pkg::ext_bus_t o_ext,
   output logic o_ext_dout_en,
   input wire logic [31:0] i_ext_din,
   input wire logic i_ext_done
);
   import ext_bus_pkg::*;

   function automatic logic [1:0] eff_port(input area_t area, input size_t port);
      if (area == AREA_MPX)
         eff_port = SZ_LONG;
      else if (area == AREA_SDRAM && port == SZ_BYTE)
         eff_port = SZ_WORD;
      else
         eff_port = port;
   endfunction

   function automatic logic [1:0] min_log(input logic [1:0] a, input logic [1:0] b);
      min_log = (a < b) ? a : b;
   endfunction

   // lowest lane of a chunk: port bytes minus offset minus chunk bytes
   function automatic logic [1:0] low_lane(input logic [1:0] a, input logic [1:0] plog,
                                           input logic [1:0] wlog);
      logic [2:0] pb;
      logic [2:0] off;
      pb = 3'd1 << plog;
      off = {1'b0, a} & (pb - 3'd1);
      low_lane = 2'(pb - off - (3'd1 << wlog));
   endfunction

   logic rst_meta_q;
   logic rst_n;
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // register bus and refresh/wait state
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0] cmp_q, cmp_d;
   logic [7:0] tcnt_q, tcnt_d;
   logic [6:0] wcnt_q, wcnt_d;
   logic en_q, en_d;
   logic cmf_q, cmf_d;
   logic pend_q, pend_d;
   logic wr_go, keyed, match, wait_busy;

   assign wr_go = i_wb_cyc && i_wb_stb && !ack_q && i_wb_we;
   assign keyed = wr_go && i_wb_sel == 4'hf
                  && i_wb_dat[KEY_LSB +: 16] == UNLOCK_KEY;
   assign match = i_refresh_tick && tcnt_q == cmp_q;
   assign wait_busy = wcnt_q != WAIT_END;

   always_comb
   begin
      ack_d = i_wb_cyc && i_wb_stb && !ack_q;
      dat_d = 32'h0;
      unique case (i_wb_adr)
         OFF_CMP: dat_d = {24'h0, cmp_q};
         OFF_WAIT: dat_d = {25'h0, wcnt_q};
         OFF_CTRL: dat_d = {28'h0, wait_busy, pend_q, cmf_q, en_q};
         OFF_TIMER: dat_d = {24'h0, tcnt_q};
         default: dat_d = 32'h0;
      endcase
      cmp_d = cmp_q;
      tcnt_d = tcnt_q;
      wcnt_d = wcnt_q;
      en_d = en_q;
      cmf_d = cmf_q;
      pend_d = pend_q;
      if (wait_busy)
         wcnt_d = wcnt_q + 7'h1;
      if (match)
         tcnt_d = 8'h0;
      else if (i_refresh_tick)
         tcnt_d = tcnt_q + 8'h1;
      if (keyed && i_wb_adr == OFF_CMP)
         cmp_d = i_wb_dat[CMP_W-1:0];
      if (keyed && i_wb_adr == OFF_TIMER)
         tcnt_d = i_wb_dat[CMP_W-1:0];
      if (keyed && i_wb_adr == OFF_WAIT)
         wcnt_d = i_wb_dat[WAIT_W-1:0];
      if (wr_go && i_wb_adr == OFF_CTRL && i_wb_sel[0])
      begin
         en_d = i_wb_dat[CTRL_EN];
         if (i_wb_dat[CTRL_CMF])
            cmf_d = 1'b0;
      end
      if (i_refresh_ack)
         pend_d = 1'b0;
      if (match)
         cmf_d = 1'b1;
      if (match && en_q)
         pend_d = 1'b1;
   end

   // only power-on reset clears the compare value
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
         cmp_q <= CMP_RESET;
         tcnt_q <= 8'h0;
         wcnt_q <= WAIT_RESET;
         en_q <= 1'b0;
         cmf_q <= 1'b0;
         pend_q <= 1'b0;
      end
      else if (i_ce)
      begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         cmp_q <= cmp_d;
         tcnt_q <= tcnt_d;
         wcnt_q <= wcnt_d;
         en_q <= en_d;
         cmf_q <= cmf_d;
         pend_q <= pend_d;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;
   assign o_refresh_req = pend_q;

   // access splitter
   xfer_state_t st_q, st_d;
   acc_req_t req_q, req_d;
   logic [1:0] plog_q, plog_d;
   logic [1:0] wlog_q, wlog_d;
   logic [1:0] left_q, left_d;
   logic [31:0] acc_q, acc_d;
   ext_bus_t ext_q, ext_d;
   logic rsp_q, rsp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] baddr;
   logic [4:0] shift;
   logic [4:0] lshift;
   logic [1:0] low;
   logic [1:0] beat_plog;
   logic [1:0] beat_wlog;
   logic [1:0] beat_left;
   logic [31:0] beat_data;
   logic [31:0] chunk;
   logic [31:0] wmask;
   logic accept;

   assign accept = st_q == ST_IDLE && i_acc_valid && !wait_busy;

   // sets up the bus image of one beat
   always_comb
   begin
      if (st_q == ST_IDLE)
      begin
         beat_plog = eff_port(i_acc.area, i_acc.size == SZ_LONG ? i_acc.port : i_acc.port);
         beat_wlog = min_log(i_acc.size, beat_plog);
         beat_left = 2'((3'd1 << (i_acc.size - beat_wlog)) - 3'd1);
         baddr = i_acc.addr;
         beat_data = i_acc.wdata;
      end
      else
      begin
         beat_plog = plog_q;
         beat_wlog = wlog_q;
         beat_left = left_q - 2'd1;
         baddr = ext_q.addr + (32'd1 << wlog_q);
         beat_data = req_q.wdata;
      end
      low = low_lane(baddr[1:0], beat_plog, beat_wlog);
      lshift = {low, 3'b000};
      shift = {beat_left, 3'b000} << beat_wlog;
      wmask = (32'h1 << ({3'b000, 2'b01} << beat_wlog << 3)) - 32'h1;
      if (beat_wlog == SZ_LONG)
         wmask = 32'hffffffff;
   end

   always_comb
   begin
      st_d = st_q;
      req_d = req_q;
      plog_d = plog_q;
      wlog_d = wlog_q;
      left_d = left_q;
      acc_d = acc_q;
      ext_d = ext_q;
      rsp_d = 1'b0;
      rdata_d = rdata_q;
      chunk = ((i_ext_din >> {low_lane(ext_q.addr[1:0], plog_q, wlog_q), 3'b000})) & wmask;
      if (accept || (st_q == ST_BEAT && i_ext_done && left_q != 2'd0))
      begin
         ext_d.addr = baddr;
         ext_d.dout = ((beat_data >> shift) & wmask) << lshift;
         ext_d.strobe = 4'(((5'd1 << (5'd1 << beat_wlog)) - 5'd1) << low);
         ext_d.sdram_mask_n = 4'hf;
         if ((accept ? i_acc.area : req_q.area) == AREA_SDRAM)
            ext_d.sdram_mask_n = ~ext_d.strobe;
         ext_d.we = accept ? i_acc.we : req_q.we;
      end
      unique case (st_q)
         ST_IDLE:
         begin
            if (accept)
            begin
               st_d = ST_BEAT;
               req_d = i_acc;
               plog_d = beat_plog;
               wlog_d = beat_wlog;
               left_d = beat_left;
               acc_d = 32'h0;
            end
         end
         ST_BEAT:
         begin
            if (i_ext_done)
            begin
               acc_d = (acc_q << ({3'b001, 2'b00} << wlog_q << 1)) | chunk;
               if (wlog_q == SZ_LONG)
                  acc_d = chunk;
               if (left_q == 2'd0)
               begin
                  st_d = ST_IDLE;
                  rsp_d = 1'b1;
                  rdata_d = acc_d;
               end
               else
                  left_d = left_q - 2'd1;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_IDLE;
         req_q <= '0;
         plog_q <= SZ_LONG;
         wlog_q <= SZ_BYTE;
         left_q <= 2'd0;
         acc_q <= 32'h0;
         ext_q <= '{addr: 32'h0, dout: 32'h0, strobe: 4'h0, sdram_mask_n: 4'hf, we: 1'b0};
         rsp_q <= 1'b0;
         rdata_q <= 32'h0;
      end
      else if (i_ce)
      begin
         st_q <= st_d;
         req_q <= req_d;
         plog_q <= plog_d;
         wlog_q <= wlog_d;
         left_q <= left_d;
         acc_q <= acc_d;
         ext_q <= ext_d;
         rsp_q <= rsp_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_acc_ready = accept;
   assign o_ext_req = st_q == ST_BEAT;
   assign o_ext = ext_q;
   assign o_ext_dout_en = st_q == ST_BEAT && ext_q.we;
   assign o_rsp_valid = rsp_q;
   assign o_rsp_rdata = rdata_q;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!rst_n);

   property p_cmp_upper;
      o_wb_ack && i_wb_adr == OFF_CMP |-> o_wb_dat[31:8] == 24'h0;
   endproperty
   a_cmp_upper: assert property (p_cmp_upper) else $error("compare upper bits set");

   property p_match;
      i_ce && match && !(keyed && i_wb_adr == OFF_TIMER) |=> tcnt_q == 8'h0 && cmf_q;
   endproperty
   a_match: assert property (p_match) else $error("match did not clear counter");

   property p_req_raise;
      i_ce && match && en_q |=> o_refresh_req;
   endproperty
   a_req_raise: assert property (p_req_raise) else $error("refresh request missing");

   property p_req_hold;
      o_refresh_req && !i_refresh_ack |=> o_refresh_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("refresh request lost");

   property p_key;
      i_ce && wr_go && i_wb_adr == OFF_CMP && !keyed |=> $stable(cmp_q);
   endproperty
   a_key: assert property (p_key) else $error("unkeyed write changed compare");

   property p_wait_count;
      i_ce && wait_busy && !keyed |=> wcnt_q == $past(wcnt_q) + 7'h1;
   endproperty
   a_wait_count: assert property (p_wait_count) else $error("wait counter step wrong");

   property p_wait_stop;
      i_ce && !wait_busy && !keyed |=> wcnt_q == WAIT_END;
   endproperty
   a_wait_stop: assert property (p_wait_stop) else $error("wait counter left its end");

   property p_hold_off;
      i_ce && wait_busy && !o_ext_req |=> !o_ext_req;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("access while waiting");

   sequence s_long8_start;
      i_ce && accept && i_acc.size == SZ_LONG && i_acc.port == SZ_BYTE
      && i_acc.area != AREA_MPX && i_acc.area != AREA_SDRAM;
   endsequence
   sequence s_beat_lane0;
      o_ext_req && o_ext.strobe == 4'h1;
   endsequence
   property p_long8;
      s_long8_start |=> s_beat_lane0 and (o_ext.addr[1:0] == $past(i_acc.addr[1:0]));
   endproperty
   a_long8: assert property (p_long8) else $error("8-bit split lane wrong");

   property p_long32;
      i_ce && accept && i_acc.size == SZ_LONG && i_acc.port == SZ_LONG |=> o_ext.strobe == 4'hf;
   endproperty
   a_long32: assert property (p_long32) else $error("longword strobes wrong");
endmodule

//--- tb/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
   import ext_bus_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_req,
   input wire ext_bus_t i_ext,
   input wire logic [2:0] i_width,
   output logic [31:0] o_din,
   output logic o_done
);
   logic [7:0] mem [16];
   logic [31:0] last_q = 32'h0;
   logic [1:0] cnt_q = 2'h0;
   logic [1:0] dly_q = 2'h0;
   logic [3:0] base;
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      o_done = 1'b0;
   end
   // lane k of a beat holds the byte at base + width - 1 - k
   always_comb
   begin
      base = i_ext.addr[3:0] & ~(4'(i_width) - 4'h1);
      o_din = ~last_q;
      for (int k = 0; k < 4; k++)
         if (i_req && !i_ext.we && k < i_width)
            o_din[8 * k +: 8] = mem[base + 4'(i_width) - 4'h1 - 4'(k)];
   end
   // answer after 0 to 3 cycles, rotating
   always @(posedge i_sys_clk)
   begin
      o_done <= 1'b0;
      if (o_done)
      begin
         cnt_q <= 2'h0;
         dly_q <= dly_q + 2'h1;
         if (!i_ext.we)
            last_q <= o_din;
         for (int k = 0; k < 4; k++)
            if (i_ext.we && i_ext.strobe[k] && k < i_width)
               mem[base + 4'(i_width) - 4'h1 - 4'(k)] <= i_ext.dout[8 * k +: 8];
      end
      else if (i_req && cnt_q == dly_q)
         o_done <= 1'b1;
      else if (i_req)
         cnt_q <= cnt_q + 2'h1;
   end
endmodule

//--- tb/ext_bus_refresh_wait_align_bench.sv
`timescale 1ns/1ps
module ext_bus_refresh_wait_align_bench;
   import ext_bus_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [3:0] i_wb_adr = 4'h0;
   logic [31:0] i_wb_dat = 32'h0;
   logic i_refresh_tick = 1'b0;
   logic i_refresh_ack = 1'b0;
   logic i_acc_valid = 1'b0;
   logic ce = 1'b1;
   logic [3:0] sel = 4'hf;
   acc_req_t i_acc = '0;
   logic [31:0] o_wb_dat, o_rsp_rdata, i_ext_din, q;
   logic [31:0] r = 32'he6824b30;
   logic o_wb_ack, o_refresh_req, o_acc_ready, o_rsp_valid, o_ext_req, i_ext_done;
   ext_bus_t o_ext;
   logic [2:0] w = 3'h4;
   logic [7:0] refm [16];
   size_t sz;
   int error_cnt = 0, num_checks = 0, beats = 0;
   realtime t0, ta;
   always #20 i_sys_clk = ~i_sys_clk;
   ext_bus_refresh_wait_align dut (.i_sys_clk, .i_arst_n, .i_ce(ce), .i_wb_cyc, .i_wb_stb,
      .i_wb_we, .i_wb_adr, .i_wb_sel(sel), .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_refresh_tick,
      .i_refresh_ack, .o_refresh_req, .i_acc_valid, .i_acc, .o_acc_ready, .o_rsp_valid,
      .o_rsp_rdata, .o_ext_req, .o_ext, .o_ext_dout_en(), .i_ext_din, .i_ext_done);
   ext_mem_model mem (.i_sys_clk, .i_req(o_ext_req), .i_ext(o_ext), .i_width(w),
      .o_din(i_ext_din), .o_done(i_ext_done));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] ew(area_t ar, size_t pt);
      if (ar == AREA_MPX)
         return 3'h4;
      if (ar == AREA_SDRAM && pt == SZ_BYTE)
         return 3'h2;
      return 3'(1 << pt);
   endfunction
   function automatic logic [3:0] strb(logic [3:0] a, size_t s, logic [2:0] wd);
      logic [3:0] m;
      m = 4'h0;
      for (int i = 0; i < ((1 << s) < wd ? (1 << s) : wd); i++)
         m[wd - 1 - ((a + i) & (wd - 1))] = 1'b1;
      return m;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do @(posedge i_sys_clk); while (!o_wb_ack);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic tick(int k);
      repeat (k)
      begin
         i_refresh_tick <= 1'b1;
         @(posedge i_sys_clk);
         i_refresh_tick <= 1'b0;
         @(posedge i_sys_clk);
      end
   endtask
   task automatic mem_op(logic we, logic [3:0] a, size_t s, area_t ar, size_t pt);
      logic [31:0] e;
      int nb;
      nb = 1 << s;
      e = 32'h0;
      r = lfsr(r);
      w = ew(ar, pt);
      beats = 0;
      i_acc <= '{{28'h0, a}, s, we, r, ar, pt};
      i_acc_valid <= 1'b1;
      do @(negedge i_sys_clk); while (!o_acc_ready);
      ta = $realtime;
      @(posedge i_sys_clk);
      i_acc_valid <= 1'b0;
      do @(negedge i_sys_clk); while (!o_rsp_valid);
      for (int i = 0; i < nb; i++)
      begin
         if (we)
            refm[a + i] = r[8 * (nb - 1 - i) +: 8];
         e = {e[23:0], refm[a + i]};
      end
      if (!we)
         chk("rdata", e, o_rsp_rdata);
      chk("beats", (nb > w) ? nb / w : 1, beats);
      @(posedge i_sys_clk);
   endtask
   // lanes and strobes of every beat
   always @(posedge i_sys_clk)
      if (o_ext_req)
      begin
         q = {28'h0, strb(o_ext.addr[3:0], i_acc.size, w)};
         chk("strobe", q, {28'h0, o_ext.strobe});
         q = (i_acc.area == AREA_SDRAM) ? ~q : 32'hf;
         chk("mask_n", q[3:0], {28'h0, o_ext.sdram_mask_n});
         beats += int'(i_ext_done);
      end
   initial
   begin
      #(40 * 40000);
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      foreach (refm[i])
         refm[i] = 8'h00;
      repeat (10) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      t0 = $realtime;
      repeat (3) @(posedge i_sys_clk);
      wb(0, OFF_CMP, 32'h0);
      chk("cmp_reset", 32'h0, q);
      do wb(0, OFF_CTRL, 32'h0); while (q[CTRL_BUSY]);
      chk("wait_span", 1, 32'(($realtime - t0) / 40 >= 127));
      @(posedge i_sys_clk);
      wb(0, OFF_WAIT, 32'h0);
      chk("wait_end", 32'h7f, q);
      wb(1, OFF_CMP, {UNLOCK_KEY, 16'hff03});
      wb(1, OFF_CMP, 32'h0000_0009);
      wb(0, OFF_CMP, 32'h0);
      chk("cmp", 32'h3, q);
      sel <= 4'h3;
      wb(1, OFF_CMP, {UNLOCK_KEY, 16'h0011});
      sel <= 4'hf;
      wb(0, OFF_CMP, 32'h0);
      chk("cmp_sel", 32'h3, q);
      wb(1, OFF_CTRL, 32'h1);
      tick(4);
      chk("req", 1, o_refresh_req);
      wb(0, OFF_TIMER, 32'h0);
      chk("timer", 32'h0, q);
      wb(0, OFF_CTRL, 32'h0);
      chk("ctrl", 32'h7, q);
      tick(4);
      chk("req_held", 1, o_refresh_req);
      i_refresh_ack <= 1'b1;
      @(posedge i_sys_clk);
      i_refresh_ack <= 1'b0;
      @(posedge i_sys_clk);
      chk("req_acked", 0, o_refresh_req);
      wb(1, OFF_TIMER, {UNLOCK_KEY, 16'h00fe});
      ce <= 1'b0;
      tick(2);
      ce <= 1'b1;
      wb(0, OFF_TIMER, 32'h0);
      chk("timer_frozen", 32'hfe, q);
      tick(2);
      wb(0, OFF_TIMER, 32'h0);
      chk("timer_wrap", 32'h0, q);
      t0 = $realtime;
      wb(1, OFF_WAIT, {UNLOCK_KEY, 16'hff70});
      wb(0, OFF_WAIT, 32'h0);
      chk("wait_hi", 32'h0, q & 32'hffff_ff80);
      wb(0, OFF_CTRL, 32'h0);
      chk("busy", 32'h8, q & 32'h8);
      mem_op(1, 4'h0, SZ_LONG, AREA_NORMAL, SZ_BYTE);
      chk("ready_held", 1, 32'((ta - t0) / 40 >= 15));
      mem_op(0, 4'h1, SZ_BYTE, AREA_BSRAM, SZ_LONG);
      mem_op(0, 4'h2, SZ_WORD, AREA_SDRAM, SZ_BYTE);
      mem_op(0, 4'h0, SZ_LONG, AREA_MPX, SZ_BYTE);
      mem_op(0, 4'h4, SZ_LONG, AREA_NORMAL, SZ_WORD);
      repeat (80)
      begin
         r = lfsr(r);
         sz = size_t'(r[7:6] % 3);
         mem_op(r[0], r[5:2] & ~4'((1 << sz) - 1), sz, area_t'(r[9:8]), size_t'(r[11:10] % 3));
      end
      tally_and_finish();
   end
endmodule
